/* src/front_panel_ctrl.sv */
/*
 * Front-panel status and control: LED colour and blink, hood latch and
 * lock bar, I/O disable with lock, processor removal flag, power button.
 * Assumes synchronous inputs; cold_rst only at cold boot; hood_bat_rst
 * only at battery insertion.
 */
// Operation
// - 62 individually configurable general-purpose pins
// - Runtime group configures pins at boot
// - S0 gives steady green power LED
// - S4 blinks green 0.5 Hz, disk dark
// - Thermal red 4 Hz; ROM error red 1 Hz
// - Crowbar blinks red 0.5 Hz, disk dark
// - Disk LED green only with S0 activity
// - Battery-backed latch records hood removal
// - Separate lock and unlock outputs
// - Disable parallel, serial, diskette independently
// - Disable lock cleared only by cold reset
// - Processor removal flagged to chipset
// - Power button drives supply-on per mode
`timescale 1ns/1ps
module front_panel_ctrl
    import fp_pkg::*;
#(
    parameter int TICK = TICK_CYCLES,
    parameter int NPINS = GP_PINS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cold_rst,
    input wire logic hood_bat_rst,
    input wire sys_state_t sys_state,
    input wire logic processor_absent,
    input wire logic thermal_trip,
    input wire logic rom_error,
    input wire logic crowbar,
    input wire logic disk_active,
    input wire logic hood_open,
    input wire logic hood_clear,
    input wire logic [1:0] lock_cmd,
    input wire logic dis_wr,
    input wire logic [2:0] dis_wdata,
    input wire logic dis_lock_wr,
    input wire logic processor_removed_input,
    input wire logic removal_ack,
    input wire logic pb_mode,
    input wire logic power_button,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_ldev,
    input wire logic [NPINS-1:0] cfg_dir,
    input wire logic [NPINS-1:0] cfg_out,
    input wire logic [NPINS-1:0] gp_in,
    output logic [NPINS-1:0] gp_out,
    output logic [NPINS-1:0] gp_oe,
    output logic [NPINS-1:0] gp_in_q,
    output logic power_led_colour_select,
    output logic power_led_blink_control,
    output logic power_led_on,
    output logic disk_led_on,
    output logic hood_removed,
    output logic hood_lock,
    output logic hood_unlock,
    output logic par_disable,
    output logic ser_disable,
    output logic fdc_disable,
    output logic dis_locked,
    output logic cpu_changed,
    output logic supply_on_output
);
    // ==============================================================
    // Blink phases
    blink_if bl ();
    blink_div #(.TICK(TICK)) u_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .bl(bl)
    );

    // ==============================================================
    // LED selection; crowbar, thermal and ROM faults take priority over power state
    led_colour_t col;
    logic blink_en, phase;
    always_comb begin
        col = LED_DARK;
        blink_en = 1'b0;
        phase = 1'b1;
        if (crowbar) begin
            col = LED_RED;
            blink_en = 1'b1;
            phase = bl.ph_05hz;
        end else if (thermal_trip) begin
            col = LED_RED;
            blink_en = 1'b1;
            phase = bl.ph_4hz;
        end else if (rom_error) begin
            col = LED_RED;
            blink_en = 1'b1;
            phase = bl.ph_1hz;
        end else if (sys_state == SYS_S5 || sys_state == SYS_OFF) begin
            col = LED_DARK;
        end else if (processor_absent) begin
            col = LED_RED;
        end else begin
            case (sys_state)
                SYS_S0: col = LED_GREEN;
                SYS_S1, SYS_S3: begin
                    col = LED_GREEN;
                    blink_en = 1'b1;
                    phase = bl.ph_1hz;
                end
                SYS_S4: begin
                    col = LED_GREEN;
                    blink_en = 1'b1;
                    phase = bl.ph_05hz;
                end
                default: col = LED_DARK;
            endcase
        end
    end

    wire pled_d = (col != LED_DARK) && phase;
    wire fault = crowbar | thermal_trip | rom_error | processor_absent;
    wire dled_d = (sys_state == SYS_S0) && !fault && disk_active;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            power_led_colour_select <= 1'b0;
            power_led_blink_control <= 1'b0;
            power_led_on <= 1'b0;
            disk_led_on <= 1'b0;
        end else begin
            power_led_colour_select <= (col == LED_GREEN);
            power_led_blink_control <= blink_en;
            power_led_on <= pled_d;
            disk_led_on <= dled_d;
        end
    end

    // ==============================================================
    // Hood latch lives on the battery domain reset, not system reset
    always_ff @(posedge sys_clk or posedge hood_bat_rst) begin
        if (hood_bat_rst)
            hood_removed <= 1'b0;
        else if (hood_open)
            hood_removed <= 1'b1;
        else if (hood_clear)
            hood_removed <= 1'b0;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hood_lock <= 1'b0;
            hood_unlock <= 1'b0;
        end else begin
            hood_lock <= (lock_cmd == LOCK_CMD_LOCK);
            hood_unlock <= (lock_cmd == LOCK_CMD_UNLOCK);
        end
    end

    // ==============================================================
    // Device disable; a warm reset leaves both lock and settings alone
    always_ff @(posedge sys_clk or posedge cold_rst) begin
        if (cold_rst) begin
            dis_locked <= 1'b0;
            par_disable <= 1'b0;
            ser_disable <= 1'b0;
            fdc_disable <= 1'b0;
        end else begin
            if (dis_wr && !dis_locked) begin
                par_disable <= dis_wdata[0];
                ser_disable <= dis_wdata[1];
                fdc_disable <= dis_wdata[2];
            end
            if (dis_lock_wr)
                dis_locked <= 1'b1;
        end
    end

    // ==============================================================
    // Processor removal, battery backed; set wins over ack
    always_ff @(posedge sys_clk or posedge hood_bat_rst) begin
        if (hood_bat_rst)
            cpu_changed <= 1'b0;
        else if (processor_removed_input)
            cpu_changed <= 1'b1;
        else if (removal_ack)
            cpu_changed <= 1'b0;
    end

    // ==============================================================
    // Power button: legacy toggles supply on each press; ACPI only
    // turns it on, and supply drops when the system enters the off state.
    logic pb_q;
    wire pb_rise = power_button && !pb_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pb_q <= 1'b0;
            supply_on_output <= 1'b0;
        end else begin
            pb_q <= power_button;
            if (pb_rise) begin
                if (pb_mode == 1'(PB_LEGACY))
                    supply_on_output <= ~supply_on_output;
                else
                    supply_on_output <= 1'b1;
            end else if (pb_mode == 1'(PB_ACPI) && sys_state == SYS_OFF)
                supply_on_output <= 1'b0;
        end
    end

    // ==============================================================
    // General-purpose pins
    wire cfg_hit = cfg_wr && (cfg_ldev == 8'(RUNTIME_LDEV));
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gp_oe <= '0;
            gp_out <= '0;
            gp_in_q <= '0;
        end else begin
            if (cfg_hit) begin
                gp_oe <= cfg_dir;
                gp_out <= cfg_out;
            end
            gp_in_q <= gp_in;
        end
    end

    // ==============================================================
    // Sampled rst in antecedents keeps the release edge vacuous:
    // outputs are still held in reset at that edge
    a_disk_dark: assert property (@(posedge sys_clk)
        disable iff (rst)
        (sys_state != SYS_S0) |=> !disk_led_on)
        else $error("disk LED lit outside S0");
    a_s0_green: assert property (@(posedge sys_clk)
        disable iff (rst)
        (sys_state == SYS_S0 && !fault && !rst) |=>
        power_led_colour_select && power_led_on && !power_led_blink_control)
        else $error("S0 not steady green");
    a_s4_green: assert property (@(posedge sys_clk)
        disable iff (rst)
        (sys_state == SYS_S4 && !fault && !rst) |=>
        power_led_colour_select && power_led_blink_control && !disk_led_on)
        else $error("S4 not blinking green");
    a_s1_green: assert property (@(posedge sys_clk)
        disable iff (rst)
        ((sys_state == SYS_S1 || sys_state == SYS_S3) && !fault && !rst)
        |=> power_led_colour_select && power_led_blink_control
        && !disk_led_on)
        else $error("suspend LED wrong");
    a_crowbar_red: assert property (@(posedge sys_clk)
        disable iff (rst)
        (crowbar && !rst) |=> !power_led_colour_select
        && power_led_blink_control && !disk_led_on)
        else $error("crowbar not red blink");
    a_thermal_red: assert property (@(posedge sys_clk)
        disable iff (rst)
        (thermal_trip && !crowbar && !rst) |=>
        !power_led_colour_select && power_led_blink_control)
        else $error("thermal not blinking red");
    a_rom_red: assert property (@(posedge sys_clk)
        disable iff (rst)
        (rom_error && !thermal_trip && !crowbar && !rst) |=>
        !power_led_colour_select && power_led_blink_control)
        else $error("ROM error not blinking red");
    a_off_dark: assert property (@(posedge sys_clk)
        disable iff (rst)
        (sys_state == SYS_S5 && !crowbar && !thermal_trip && !rom_error)
        |=> !power_led_on)
        else $error("S5 power LED lit");
    a_absent_red: assert property (@(posedge sys_clk)
        disable iff (rst)
        (processor_absent && sys_state == SYS_S0 && !crowbar
        && !thermal_trip && !rom_error && !rst) |=> power_led_on
        && !power_led_colour_select && !power_led_blink_control)
        else $error("absent processor not steady red");
    a_hood_set: assert property (@(posedge sys_clk)
        disable iff (hood_bat_rst)
        hood_open |=> hood_removed ##1 (hood_removed || $past(hood_clear)))
        else $error("hood latch lost");
    a_lock_holds: assert property (@(posedge sys_clk)
        disable iff (cold_rst)
        (dis_locked && dis_wr) |=> $stable(par_disable)
        && $stable(ser_disable) && $stable(fdc_disable))
        else $error("locked disable changed");
    a_lock_sticky: assert property (@(posedge sys_clk)
        disable iff (cold_rst)
        dis_locked |=> dis_locked)
        else $error("lock cleared without cold reset");
    a_removal_flag: assert property (@(posedge sys_clk)
        disable iff (hood_bat_rst)
        processor_removed_input |=> cpu_changed)
        else $error("removal not flagged");
    a_unlock_drive: assert property (@(posedge sys_clk)
        disable iff (rst)
        (lock_cmd == LOCK_CMD_UNLOCK && !rst) |=> hood_unlock && !hood_lock)
        else $error("unlock command not driven");
    a_legacy_toggle: assert property (@(posedge sys_clk)
        disable iff (rst)
        (pb_rise && pb_mode == 1'(PB_LEGACY) && !rst) |=>
        supply_on_output != $past(supply_on_output))
        else $error("legacy button did not toggle");
    a_acpi_off: assert property (@(posedge sys_clk)
        disable iff (rst)
        (pb_mode == 1'(PB_ACPI) && !pb_rise && sys_state == SYS_OFF)
        |=> !supply_on_output)
        else $error("ACPI supply not dropped in off state");
    a_pin_cfg: assert property (@(posedge sys_clk)
        disable iff (rst)
        (cfg_hit && !rst) |=> gp_oe == $past(cfg_dir)
        && gp_out == $past(cfg_out))
        else $error("pin config not applied");

    c_suspend: cover property (@(posedge sys_clk) disable iff (rst)
        sys_state == SYS_S3 ##1 power_led_blink_control);
    c_lock: cover property (@(posedge sys_clk) disable iff (rst)
        dis_locked && dis_wr);
    c_acpi_on: cover property (@(posedge sys_clk) disable iff (rst)
        pb_rise && pb_mode == 1'(PB_ACPI));
    c_hood: cover property (@(posedge sys_clk) disable iff (rst)
        hood_open ##1 hood_removed);
endmodule

/* src/fp_pkg.sv */
/*
 * Package for the front-panel status and control block: system states,
 * blink timing, pin counts and command codes.
 * Assumes a 250 MHz system clock.
 */
package fp_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int GP_PINS = 62;
    localparam int RUNTIME_LDEV = 8'h0A;
    // Blink half periods in milliseconds
    localparam int HALF_4HZ_MS = 125;
    localparam int HALF_1HZ_MS = 500;
    localparam int HALF_05HZ_MS = 1000;
    // Base tick of 125 ms; slower rates are multiples of it
    localparam int TICK_CYCLES = CLK_HZ / 1000 * HALF_4HZ_MS;
    localparam int DIV_1HZ = HALF_1HZ_MS / HALF_4HZ_MS;
    localparam int DIV_05HZ = HALF_05HZ_MS / HALF_4HZ_MS;
    localparam logic [1:0] LOCK_CMD_NONE = 2'h0;
    localparam logic [1:0] LOCK_CMD_LOCK = 2'h1;
    localparam logic [1:0] LOCK_CMD_UNLOCK = 2'h2;
    localparam int PB_LEGACY = 0;
    localparam int PB_ACPI = 1;

    typedef enum logic [2:0] {
        SYS_S0, SYS_S1, SYS_S3, SYS_S4, SYS_S5, SYS_OFF
    } sys_state_t;

    typedef enum logic [1:0] {
        LED_DARK, LED_GREEN, LED_RED
    } led_colour_t;
endpackage

/* src/blink_if.sv */
/*
 * Interface carrying blink phases from the divider to the LED logic.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
interface blink_if;
    logic ph_4hz;
    logic ph_1hz;
    logic ph_05hz;
    modport src (output ph_4hz, output ph_1hz, output ph_05hz);
    modport dst (input ph_4hz, input ph_1hz, input ph_05hz);
endinterface

/* src/blink_div.sv */
/*
 * Blink divider: square-wave phases at 4 Hz, 1 Hz and 0.5 Hz.
 * Assumes sys_clk at the package rate; TICK shortens in simulation.
 */
`timescale 1ns/1ps
module blink_div
    import fp_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    blink_if.src bl
);
    logic [27:0] cnt_q;
    // Bit k of the tick count toggles every 2**k ticks
    logic [3:0] slow_q;
    logic ph4_q;
    logic tick;

    assign tick = (cnt_q == 28'(TICK - 1));

    // Equal halves: every phase toggles on whole ticks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 28'h0;
            slow_q <= 4'h0;
            ph4_q <= 1'b0;
        end else if (tick) begin
            cnt_q <= 28'h0;
            ph4_q <= ~ph4_q;
            slow_q <= slow_q + 4'h1;
        end else begin
            cnt_q <= cnt_q + 28'h1;
        end
    end

    assign bl.ph_4hz = ph4_q;
    assign bl.ph_1hz = slow_q[$clog2(DIV_1HZ)];
    assign bl.ph_05hz = slow_q[$clog2(DIV_05HZ)];
endmodule

/* verif/panel_model.sv */
/*
 * Far-side model: hood switch, power button and a watcher that measures
 * the half period of the lit power LED.
 * Assumes one free-running sys_clk from the bench.
 */
`timescale 1ns/1ps
module panel_model (
    input wire logic sys_clk,
    input wire logic power_led_on,
    output logic hood_open,
    output logic power_button,
    output int half_cycles
);
    logic led_q;
    int cnt;

    initial begin
        hood_open = 1'b0;
        power_button = 1'b0;
        half_cycles = 0;
        cnt = 0;
        led_q = 1'b0;
    end

    // ====================
    // Switches
    // Button is a short pulse, released before the next press
    task automatic press();
        @(posedge sys_clk) power_button <= 1'b1;
        repeat (3) @(posedge sys_clk);
        power_button <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic open_hood();
        @(posedge sys_clk) hood_open <= 1'b1;
        repeat (3) @(posedge sys_clk);
        hood_open <= 1'b0;
    endtask

    // ====================
    // LED watcher
    // Stale while the LED is steady; only read when blinking
    always @(posedge sys_clk) begin
        led_q <= power_led_on;
        if (power_led_on !== led_q) begin
            half_cycles <= cnt;
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* verif/tb_top.sv */
/*
 * Self-checking bench for the front-panel block, seeded random stimulus.
 * Assumes the design answers one cycle after each input; TICK shortened.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
$display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
    import fp_pkg::*;
    localparam int TK = 4;
    logic sys_clk, rst, cold_rst, hood_bat_rst, processor_absent;
    logic thermal_trip, rom_error, crowbar, disk_active, hood_open;
    logic hood_clear, dis_wr, dis_lock_wr, processor_removed_input;
    logic removal_ack, pb_mode, power_button, cfg_wr;
    logic power_led_colour_select, power_led_blink_control, power_led_on;
    logic disk_led_on, hood_removed, hood_lock, hood_unlock, par_disable;
    logic ser_disable, fdc_disable, dis_locked, cpu_changed;
    logic supply_on_output;
    sys_state_t sys_state;
    logic [1:0] lock_cmd;
    logic [2:0] dis_wdata, d;
    logic [7:0] cfg_ldev;
    logic [61:0] cfg_dir, cfg_out, gp_in, gp_out, gp_oe, gp_in_q, ed, eo;
    logic [63:0] r64;
    int half_cycles, fail_count, num_checks, seed;

    front_panel_ctrl #(.TICK(TK)) i_front_panel_ctrl (
        .sys_clk(sys_clk), .rst(rst), .cold_rst(cold_rst),
        .hood_bat_rst(hood_bat_rst), .sys_state(sys_state),
        .processor_absent(processor_absent), .thermal_trip(thermal_trip),
        .rom_error(rom_error), .crowbar(crowbar), .disk_active(disk_active),
        .hood_open(hood_open), .hood_clear(hood_clear), .lock_cmd(lock_cmd),
        .dis_wr(dis_wr), .dis_wdata(dis_wdata), .dis_lock_wr(dis_lock_wr),
        .processor_removed_input(processor_removed_input),
        .removal_ack(removal_ack), .pb_mode(pb_mode),
        .power_button(power_button), .cfg_wr(cfg_wr), .cfg_ldev(cfg_ldev),
        .cfg_dir(cfg_dir), .cfg_out(cfg_out), .gp_in(gp_in),
        .gp_out(gp_out), .gp_oe(gp_oe), .gp_in_q(gp_in_q),
        .power_led_colour_select(power_led_colour_select),
        .power_led_blink_control(power_led_blink_control),
        .power_led_on(power_led_on), .disk_led_on(disk_led_on),
        .hood_removed(hood_removed), .hood_lock(hood_lock),
        .hood_unlock(hood_unlock), .par_disable(par_disable),
        .ser_disable(ser_disable), .fdc_disable(fdc_disable),
        .dis_locked(dis_locked), .cpu_changed(cpu_changed),
        .supply_on_output(supply_on_output)
    );
    panel_model i_panel_model (
        .sys_clk(sys_clk), .power_led_on(power_led_on),
        .hood_open(hood_open), .power_button(power_button),
        .half_cycles(half_cycles)
    );

    always #2 sys_clk = ~sys_clk;

    // ====================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic settle();
        cyc(2);
        @(negedge sys_clk);
    endtask

    function automatic int exp_half(input int i);
        case (i)
            1, 2, 8: return TK * DIV_1HZ;
            3, 9: return TK * DIV_05HZ;
            7: return TK;
            default: return 0;
        endcase
    endfunction

    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic dis_write(input logic [2:0] v, input logic lk);
        @(posedge sys_clk) dis_wr <= 1'b1;
        dis_wdata <= v;
        dis_lock_wr <= lk;
        @(posedge sys_clk) dis_wr <= 1'b0;
        dis_lock_wr <= 1'b0;
        settle();
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        finish_test();
    end

    // ====================
    // Main sequence
    initial begin
        {sys_clk, rst, cold_rst, hood_bat_rst} = 4'hF;
        {processor_absent, thermal_trip, rom_error, crowbar} = 4'h0;
        {disk_active, hood_clear, dis_wr, dis_lock_wr, cfg_wr} = 5'h00;
        {processor_removed_input, removal_ack, pb_mode} = 3'h0;
        sys_state = SYS_S0;
        lock_cmd = LOCK_CMD_NONE;
        dis_wdata = 3'h0;
        cfg_ldev = 8'h00;
        {cfg_dir, cfg_out, gp_in, ed, eo} = '0;
        {fail_count, num_checks, seed} = {32'h0, 32'h0, 32'h4B};
        cyc(2);
        {rst, cold_rst, hood_bat_rst} <= 3'h0;
        settle();
        `CHK(supply_on_output, 1'b0)
        `CHK(dis_locked, 1'b0)
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            sys_state <= (i == 1) ? SYS_S1 : (i == 2) ? SYS_S3 :
                (i == 3) ? SYS_S4 : (i == 4) ? SYS_S5 :
                (i == 5) ? SYS_OFF : SYS_S0;
            {processor_absent, thermal_trip} <= {i == 6, i == 7};
            {rom_error, crowbar, disk_active} <= {i == 8, i == 9, 1'b1};
            cyc(100);
            @(negedge sys_clk);
            `CHK(power_led_colour_select, (i <= 3))
            `CHK(power_led_blink_control, (exp_half(i) != 0))
            if (exp_half(i) != 0) `CHK(half_cycles, exp_half(i))
            else `CHK(power_led_on, (i == 0 || i == 6))
            `CHK(disk_led_on, (i == 0))
        end
        for (int k = 0; k < 4; k++) begin
            r64 = {$random(seed), $random(seed)};
            @(posedge sys_clk) cfg_wr <= 1'b1;
            cfg_ldev <= (k == 3) ? 8'h0B : 8'(RUNTIME_LDEV);
            {cfg_dir, cfg_out, gp_in} <= {r64[61:0], ~r64[63:2], r64[62:1]};
            @(posedge sys_clk) cfg_wr <= 1'b0;
            settle();
            if (k < 3) {ed, eo} = {r64[61:0], ~r64[63:2]};
            `CHK(gp_oe, ed)
            `CHK(gp_out & ed, eo & ed)
            `CHK(gp_in_q, r64[62:1])
        end
        i_panel_model.open_hood();
        settle();
        `CHK(hood_removed, 1'b1)
        @(posedge sys_clk) rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        settle();
        `CHK(hood_removed, 1'b1)
        @(posedge sys_clk) hood_clear <= 1'b1;
        @(posedge sys_clk) hood_clear <= 1'b0;
        settle();
        `CHK(hood_removed, 1'b0)
        for (int c = 2; c >= 0; c--) begin
            @(posedge sys_clk) lock_cmd <= 2'(c);
            settle();
            `CHK({hood_lock, hood_unlock}, {c == 1, c == 2})
        end
        for (int k = 0; k < 4; k++) begin
            d = 3'($random(seed));
            dis_write(d, k == 3);
            `CHK({fdc_disable, ser_disable, par_disable}, d)
        end
        // Locked: write must not land, plain reset must not unlock
        dis_write(~d, 1'b0);
        `CHK({fdc_disable, ser_disable, par_disable}, d)
        @(posedge sys_clk) rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        settle();
        `CHK({dis_locked, fdc_disable, ser_disable, par_disable}, {1'b1, d})
        @(posedge sys_clk) cold_rst <= 1'b1;
        cyc(2);
        cold_rst <= 1'b0;
        settle();
        `CHK({dis_locked, fdc_disable, ser_disable, par_disable}, 4'h0)
        @(posedge sys_clk) processor_removed_input <= 1'b1;
        @(posedge sys_clk) processor_removed_input <= 1'b0;
        settle();
        `CHK(cpu_changed, 1'b1)
        @(posedge sys_clk) removal_ack <= 1'b1;
        @(posedge sys_clk) removal_ack <= 1'b0;
        settle();
        `CHK(cpu_changed, 1'b0)
        i_panel_model.press();
        `CHK(supply_on_output, 1'b1)
        i_panel_model.press();
        `CHK(supply_on_output, 1'b0)
        @(posedge sys_clk) pb_mode <= 1'b1;
        i_panel_model.press();
        `CHK(supply_on_output, 1'b1)
        @(posedge sys_clk) sys_state <= SYS_OFF;
        settle();
        `CHK(supply_on_output, 1'b0)
        finish_test();
    end
endmodule
